// >>> dv/can_accept_mask_irq_tb.sv
`timescale 1ns/1ps
// ----------------------------------------
// Bench
// ----------------------------------------
module can_accept_mask_irq_tb;
    localparam logic [7:0] o_en = can_accept_pkg::interrupt_enable_offset;
    localparam logic [7:0] o_pn = can_accept_pkg::interrupt_pending_offset;
    localparam logic [7:0] o_cl = can_accept_pkg::interrupt_clear_offset;
    localparam logic [7:0] o_ce = can_accept_pkg::interrupt_code_enable_offset;
    localparam logic [7:0] o_st = can_accept_pkg::node_status_and_code_offset;
    localparam logic [7:0] o_cf = can_accept_pkg::config_offset;
    logic aclk, aresetn;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb, check_buffer;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [28:0] rx_id, buf_id, accept_id, rid, bid;
    logic rx_ide, rx_rtr, rx_srr, buf_ide, buf_rtr, buf_srr, accept_hit, irq;
    logic [14:0] buffer_done;
    logic bus_error, error_counter_inc;
    logic [2:0] node_state, rc, bc;
    logic [31:0] rdat, glob, last, f, v;
    logic [29:0] ex;
    logic [15:0] pend;
    logic [7:0] offs [10];
    int errors, compares, seed, i, k, n;
    can_accept_mask_irq dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_id, .rx_ide, .rx_rtr, .rx_srr,
        .check_buffer, .buf_id, .buf_ide, .buf_rtr, .buf_srr, .accept_hit, .accept_id,
        .buffer_done, .bus_error, .error_counter_inc, .node_state, .irq);
    engine_model model (.aclk, .buffer_done, .bus_error, .error_counter_inc, .node_state);
    initial
    begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic complete_run;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= {16'h0000, d};
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int t = 0; t < 64; t++)
        begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid)
            begin
                resp = s_axi_bresp;
                s_axi_bready <= 1'b0;
                return;
            end
        end
        errors++;
        complete_run();
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int t = 0; t < 64; t++)
        begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid)
            begin
                rdat = s_axi_rdata;
                resp = s_axi_rresp;
                s_axi_rready <= 1'b0;
                return;
            end
        end
        errors++;
        complete_run();
    endtask
    function automatic logic [29:0] exp_accept(input logic [31:0] m, input logic [28:0] ri,
        input logic [28:0] bi, input logic [2:0] r, input logic [2:0] b);
        logic [28:0] im;
        logic h;
        im = {m[31:21], m[18:16], m[15:1]};
        if (!r[2])
            im[17:0] = 18'h3ffff;
        h = (((ri ^ bi) & ~im) == 29'h0) && !((r[2] ^ b[2]) & ~m[19]);
        if (r[2])
            h = h && !((r[0] ^ b[0]) & ~m[20]) && !((r[1] ^ b[1]) & ~m[0]);
        else
            h = h && !((r[1] ^ b[1]) & ~m[20]);
        return {h, (ri & im) | (bi & ~im)};
    endfunction
    function automatic logic [4:0] exp_code(input logic [15:0] p, input logic [15:0] c);
        exp_code = 5'h00;
        for (int j = 14; j >= 0; j--)
            if (p[j] & c[j])
                exp_code = 5'h10 | 5'(j + 1);
        if (p[15] & c[15])
            exp_code = 5'h10;
    endfunction
    task automatic status(input logic [15:0] c);
        rd(o_st);
        check("code", rdat[4:0], exp_code(pend, c));
    endtask
    initial
    begin
        seed = 32'hd256;
        errors = 0;
        compares = 0;
        aresetn = 1'b0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hf;
        {rx_id, rx_ide, rx_rtr, rx_srr, buf_id, buf_ide, buf_rtr, buf_srr} = '0;
        check_buffer = 4'h0;
        offs = '{8'h00, 8'h04, 8'h08, 8'h0c, o_en, o_pn, o_cl, o_ce, o_st, o_cf};
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        for (k = 0; k < 10; k++)
        begin
            rd(offs[k]);
            check("reset", rdat, 32'h0);
        end
        for (k = 0; k < 8; k++)
        begin
            if (k == 5 || k == 6)
                continue;
            v = $random(seed);
            wr(offs[k], v[15:0]);
            rd(offs[k]);
            check("rw", rdat, {16'h0000, v[15:0]});
        end
        wr(o_cl, 16'hffff);
        rd(o_cl);
        check("clear read", rdat, 32'h0);
        wr(o_pn, 16'hffff);
        rd(o_pn);
        check("pending ro", rdat, 32'h0);
        wr(8'h28, 16'h1234);
        check("unmapped wr", resp, can_accept_pkg::resp_slverr);
        rd(8'h28);
        check("unmapped rd", resp, can_accept_pkg::resp_slverr);
        $display("test registers done");
        for (k = 0; k < 4; k++)
        begin
            glob = (k == 0) ? 32'h0 : (k == 3) ? 32'hffffffff : $random(seed);
            last = (k == 0) ? 32'h0 : (k == 3) ? 32'hffffffff : $random(seed);
            wr(8'h00, glob[31:16]);
            wr(8'h04, glob[15:0]);
            wr(8'h08, last[31:16]);
            wr(8'h0c, last[15:0]);
            for (i = 0; i < 90; i++)
            begin
                f = $random(seed) & $random(seed) & $random(seed);
                {rc, rid} = $random(seed);
                bid = rid ^ f[28:0];
                bc = rc ^ f[31:29];
                n = (i % 3 == 0) ? 14 : $unsigned($random(seed)) % 14;
                ex = exp_accept((n == 14) ? last : glob, rid, bid, rc, bc);
                @(posedge aclk);
                {rx_id, rx_ide, rx_rtr, rx_srr} <= {rid, rc};
                {buf_id, buf_ide, buf_rtr, buf_srr} <= {bid, bc};
                check_buffer <= 4'(n);
                @(posedge aclk);
                @(negedge aclk);
                check("hit", accept_hit, ex[29]);
                if (ex[29] && rc[2])
                    check("id", accept_id, ex[28:0]);
                else if (ex[29])
                    check("id", accept_id[28:18], ex[28:18]);
            end
        end
        $display("test acceptance done");
        wr(o_ce, 16'hffff);
        wr(o_en, 16'h0000);
        wr(o_cf, 16'h0000);
        for (n = 0; n < 15; n++)
        begin
            pend = 16'(1 << n);
            model.pulse(pend[14:0], 1'b0, 1'b0, 3'h2);
            rd(o_pn);
            check("pending", rdat, {16'h0000, pend});
            check("irq off", irq, 1'b0);
            wr(o_en, pend);
            @(negedge aclk);
            check("irq on", irq, 1'b1);
            model.pulse(pend[14:0], 1'b0, 1'b0, 3'h2);
            status(16'hffff);
            wr(o_cl, ~pend);
            rd(o_pn);
            check("clear zero", rdat, {16'h0000, pend});
            wr(o_cl, pend);
            pend = 16'h0000;
            rd(o_pn);
            check("clear one", rdat, 32'h0);
            check("irq gone", irq, 1'b0);
            wr(o_en, 16'h0000);
        end
        n = $unsigned($random(seed)) % 14;
        pend = 16'(1 << n) | 16'h4000;
        model.pulse(pend[14:0], 1'b0, 1'b0, 3'h2);
        wr(o_en, 16'h7fff);
        status(16'hffff);
        wr(o_ce, ~pend | 16'h4000);
        status(~pend | 16'h4000);
        wr(o_ce, 16'h0000);
        status(16'h0000);
        check("irq ungated", irq, 1'b1);
        wr(o_ce, 16'hffff);
        wr(o_en, 16'h0000);
        model.pulse(15'h0008, 1'b1, 1'b0, 3'h2);
        pend = pend | 16'h8008;
        rd(o_pn);
        check("error set", rdat, {16'h0000, pend});
        status(16'hffff);
        check("err irq off", irq, 1'b0);
        wr(o_en, 16'h8000);
        @(negedge aclk);
        check("err irq on", irq, 1'b1);
        wr(o_cl, 16'h0000);
        rd(o_pn);
        check("error kept", rdat[15], 1'b1);
        wr(o_cl, 16'hffff);
        rd(o_pn);
        check("error clear", rdat, 32'h0);
        wr(o_cf, 16'h0001);
        model.pulse(15'h0000, 1'b1, 1'b1, 3'h2);
        rd(o_pn);
        check("type one same", rdat, 32'h0);
        model.pulse(15'h0000, 1'b0, 1'b1, 3'h3);
        rd(o_pn);
        check("type one change", rdat, 32'h8000);
        wr(o_cl, 16'h8000);
        pend = 16'h0000;
        $display("test interrupts done");
        for (k = 0; k < 8; k++)
        begin
            model.pulse(15'h0000, 1'b0, 1'b0, 3'(k));
            rd(o_st);
            check("node state", rdat, {24'h0, 3'(k), 5'h00});
        end
        $display("test node state done");
        complete_run();
    end
endmodule

// >>> dv/engine_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Event source in place of the protocol engine
// ----------------------------------------
module engine_model (
    // Clock
    input wire logic aclk,
    // Events
    output logic [14:0] buffer_done,
    output logic bus_error,
    output logic error_counter_inc,
    output logic [2:0] node_state
);
    initial
    begin
        buffer_done = 15'h0000;
        bus_error = 1'b0;
        error_counter_inc = 1'b0;
        node_state = 3'h0;
    end
    // One-cycle event pulses, state level held
    task automatic pulse(input logic [14:0] d, input logic e, input logic i, input logic [2:0] s);
        @(posedge aclk);
        buffer_done <= d;
        bus_error <= e;
        error_counter_inc <= i;
        node_state <= s;
        @(posedge aclk);
        buffer_done <= 15'h0000;
        bus_error <= 1'b0;
        error_counter_inc <= 1'b0;
    endtask
endmodule

// >>> verilog/accept_filter.sv
`timescale 1ns/1ps
module accept_filter (
    // Compare path
    accept_if.filter f
);
    // ----------------------------------------
    // Mask layout: {high 28:18,rtr,ide,17:15, low 14:0,extended_remote_mask}
    // ----------------------------------------
    logic [28:0] id_dc;
    logic rtr_dc;
    logic ide_dc;
    logic extended_remote_mask_dc;
    logic [28:0] used;
    logic [28:0] diff;
    logic ctl_ok;
    always_comb
    begin
        id_dc = {f.mask[31:21], f.mask[18:16], f.mask[15:1]};
        rtr_dc = f.mask[20];
        ide_dc = f.mask[19];
        extended_remote_mask_dc = f.mask[0];
        used = f.rx_ide ? 29'h1fffffff : {11'h7ff, 18'h00000};
        diff = (f.rx_id ^ f.buf_id) & ~id_dc & used;
        ctl_ok = (ide_dc || f.rx_ide == f.buf_ide)
            && (rtr_dc || (f.rx_ide ? f.rx_srr == f.buf_srr : f.rx_rtr == f.buf_rtr))
            && (!f.rx_ide || extended_remote_mask_dc || f.rx_rtr == f.buf_rtr);
        f.hit = (diff == 29'h0) && ctl_ok;
        f.merged_id = (f.buf_id & ~(id_dc & used)) | (f.rx_id & id_dc & used);
    end
endmodule

// >>> verilog/accept_if.sv
`timescale 1ns/1ps
interface accept_if;
    logic [28:0] rx_id;
    logic rx_ide;
    logic rx_rtr;
    logic rx_srr;
    logic [28:0] buf_id;
    logic buf_ide;
    logic buf_rtr;
    logic buf_srr;
    logic [31:0] mask;
    logic hit;
    logic [28:0] merged_id;
    modport engine (output rx_id, rx_ide, rx_rtr, rx_srr, buf_id, buf_ide, buf_rtr, buf_srr,
        mask, input hit, merged_id);
    modport filter (input rx_id, rx_ide, rx_rtr, rx_srr, buf_id, buf_ide, buf_rtr, buf_srr,
        mask, output hit, merged_id);
endinterface

// >>> verilog/can_accept_mask_irq.sv
// The placing of the registers and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
module can_accept_mask_irq (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Acceptance check from protocol engine
    input wire logic [28:0] rx_id,
    input wire logic rx_ide,
    input wire logic rx_rtr,
    input wire logic rx_srr,
    input wire logic [3:0] check_buffer,
    input wire logic [28:0] buf_id,
    input wire logic buf_ide,
    input wire logic buf_rtr,
    input wire logic buf_srr,
    output logic accept_hit,
    output logic [28:0] accept_id,
    // Events from protocol engine
    input wire logic [14:0] buffer_done,
    input wire logic bus_error,
    input wire logic error_counter_inc,
    input wire logic [2:0] node_state,
    // Interrupt request
    output logic irq
);
    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [15:0] global_mask_high_q;
    logic [15:0] global_mask_low_q;
    logic [15:0] last_buffer_mask_high_q;
    logic [15:0] last_buffer_mask_low_q;
    logic [15:0] interrupt_enable_q;
    logic [15:0] interrupt_pending_q;
    logic [15:0] interrupt_code_enable_q;
    logic error_irq_type_q;
    logic [2:0] node_state_q;
    logic [2:0] node_state_prev_q;
    logic [4:0] code_q;
    logic [4:0] code_d;
    logic irq_d;
    logic [15:0] clear_d;
    logic err_event;
    logic [15:0] wval;
    logic aw_held_q;
    logic w_held_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic do_write;
    logic [15:0] code_src;
    accept_if acc ();

    // ----------------------------------------
    // Acceptance filter
    // ----------------------------------------
    always_comb
    begin
        acc.rx_id = rx_id;
        acc.rx_ide = rx_ide;
        acc.rx_rtr = rx_rtr;
        acc.rx_srr = rx_srr;
        acc.buf_id = buf_id;
        acc.buf_ide = buf_ide;
        acc.buf_rtr = buf_rtr;
        acc.buf_srr = buf_srr;
        if (check_buffer == 4'(can_accept_pkg::last_buffer))
            acc.mask = {last_buffer_mask_high_q, last_buffer_mask_low_q};
        else
            acc.mask = {global_mask_high_q, global_mask_low_q};
    end

    accept_filter u_filter (
        .f(acc.filter)
    );

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            accept_hit <= 1'b0;
            accept_id <= 29'h0;
        end
        else
        begin
            accept_hit <= acc.hit;
            accept_id <= acc.merged_id;
        end
    end

    // ----------------------------------------
    // Write channel
    // ----------------------------------------
    assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= can_accept_pkg::resp_okay;
        end
        else
        begin
            s_axi_awready <= !aw_held_q && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready <= !w_held_q && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_write)
            begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (awaddr_q > can_accept_pkg::config_offset
                    || awaddr_q[1:0] != 2'h0) ? can_accept_pkg::resp_slverr
                    : can_accept_pkg::resp_okay;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    function automatic logic [15:0] merge16(input logic [15:0] old,
        input logic [31:0] data, input logic [3:0] strb);
        merge16 = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
    endfunction

    assign wval = merge16(16'h0000, wdata_q, wstrb_q);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            global_mask_high_q <= can_accept_pkg::reg_reset;
            global_mask_low_q <= can_accept_pkg::reg_reset;
            last_buffer_mask_high_q <= can_accept_pkg::reg_reset;
            last_buffer_mask_low_q <= can_accept_pkg::reg_reset;
            interrupt_enable_q <= can_accept_pkg::reg_reset;
            interrupt_code_enable_q <= can_accept_pkg::reg_reset;
            error_irq_type_q <= 1'b0;
        end
        else if (do_write)
        begin
            unique case (awaddr_q)
                can_accept_pkg::global_mask_high_offset:
                    global_mask_high_q <= merge16(global_mask_high_q, wdata_q, wstrb_q);
                can_accept_pkg::global_mask_low_offset:
                    global_mask_low_q <= merge16(global_mask_low_q, wdata_q, wstrb_q);
                can_accept_pkg::last_buffer_mask_high_offset:
                    last_buffer_mask_high_q <= merge16(last_buffer_mask_high_q, wdata_q,
                        wstrb_q);
                can_accept_pkg::last_buffer_mask_low_offset:
                    last_buffer_mask_low_q <= merge16(last_buffer_mask_low_q, wdata_q,
                        wstrb_q);
                can_accept_pkg::interrupt_enable_offset:
                    interrupt_enable_q <= merge16(interrupt_enable_q, wdata_q, wstrb_q);
                can_accept_pkg::interrupt_code_enable_offset:
                    interrupt_code_enable_q <= merge16(interrupt_code_enable_q, wdata_q,
                        wstrb_q);
                can_accept_pkg::config_offset:
                    if (wstrb_q[0])
                        error_irq_type_q <= wdata_q[0];
                default:
                    ;
            endcase
        end
    end

    // ----------------------------------------
    // Pending flags
    // ----------------------------------------
    always_comb
    begin
        clear_d = 16'h0000;
        if (do_write && awaddr_q == can_accept_pkg::interrupt_clear_offset)
            clear_d = wval;
        err_event = error_irq_type_q ? (error_counter_inc && node_state != node_state_prev_q)
            : bus_error;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            interrupt_pending_q <= can_accept_pkg::reg_reset;
            node_state_prev_q <= 3'h0;
            node_state_q <= 3'h0;
        end
        else
        begin
            node_state_prev_q <= node_state;
            node_state_q <= node_state;
            // Set wins over clear
            interrupt_pending_q <= (interrupt_pending_q & ~clear_d)
                | {err_event, buffer_done};
        end
    end

    // ----------------------------------------
    // Interrupt code and request
    // ----------------------------------------
    always_comb
    begin
        code_src = interrupt_pending_q & interrupt_code_enable_q;
        code_d = 5'h00;
        for (int i = can_accept_pkg::last_buffer; i >= 0; i--)
            if (code_src[i])
                code_d = {1'b1, 4'(i + 1)};
        if (code_src[can_accept_pkg::error_bit])
            code_d = 5'h10;
        irq_d = |(interrupt_pending_q & interrupt_enable_q);
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            code_q <= 5'h00;
            irq <= 1'b0;
        end
        else
        begin
            code_q <= code_d;
            irq <= irq_d;
        end
    end

    // ----------------------------------------
    // Read channel
    // ----------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= can_accept_pkg::resp_okay;
        end
        else
        begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= can_accept_pkg::resp_okay;
                unique case (s_axi_araddr)
                    can_accept_pkg::global_mask_high_offset:
                        s_axi_rdata <= {16'h0, global_mask_high_q};
                    can_accept_pkg::global_mask_low_offset:
                        s_axi_rdata <= {16'h0, global_mask_low_q};
                    can_accept_pkg::last_buffer_mask_high_offset:
                        s_axi_rdata <= {16'h0, last_buffer_mask_high_q};
                    can_accept_pkg::last_buffer_mask_low_offset:
                        s_axi_rdata <= {16'h0, last_buffer_mask_low_q};
                    can_accept_pkg::interrupt_enable_offset:
                        s_axi_rdata <= {16'h0, interrupt_enable_q};
                    can_accept_pkg::interrupt_pending_offset:
                        s_axi_rdata <= {16'h0, interrupt_pending_q};
                    can_accept_pkg::interrupt_clear_offset:
                        s_axi_rdata <= 32'h0;
                    can_accept_pkg::interrupt_code_enable_offset:
                        s_axi_rdata <= {16'h0, interrupt_code_enable_q};
                    can_accept_pkg::node_status_and_code_offset:
                        s_axi_rdata <= {24'h0, node_state_q, code_q};
                    can_accept_pkg::config_offset:
                        s_axi_rdata <= {31'h0, error_irq_type_q};
                    default:
                    begin
                        s_axi_rdata <= 32'h0;
                        s_axi_rresp <= can_accept_pkg::resp_slverr;
                    end
                endcase
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence s_buf_event;
        buffer_done[0] && interrupt_enable_q[0];
    endsequence

    a_irq_follows_enable: assert property (@(posedge aclk) disable iff (!aresetn)
        (|(interrupt_pending_q & interrupt_enable_q)) |=> irq)
        else $error("irq missing");
    a_irq_idle: assert property (@(posedge aclk) disable iff (!aresetn)
        !(|(interrupt_pending_q & interrupt_enable_q)) |=> !irq)
        else $error("spurious irq");
    a_buf_pending_set: assert property (@(posedge aclk) disable iff (!aresetn)
        buffer_done[3] |=> interrupt_pending_q[3])
        else $error("pending not set");
    a_buf_irq_seq: assert property (@(posedge aclk) disable iff (!aresetn)
        s_buf_event |=> ##1 irq)
        else $error("buffer irq missing");
    a_error_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
        interrupt_pending_q[15] && !clear_d[15] |=> interrupt_pending_q[15])
        else $error("error pending lost");
    a_clear_works: assert property (@(posedge aclk) disable iff (!aresetn)
        clear_d[2] && !buffer_done[2] |=> !interrupt_pending_q[2])
        else $error("clear failed");
    a_err_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        clear_d[15] && !err_event |=> !interrupt_pending_q[15])
        else $error("error clear failed");
    a_code_error_first: assert property (@(posedge aclk) disable iff (!aresetn)
        interrupt_pending_q[15] && interrupt_code_enable_q[15] |=> code_q == 5'h10)
        else $error("error not top");
    a_code_gated: assert property (@(posedge aclk) disable iff (!aresetn)
        (interrupt_pending_q & interrupt_code_enable_q) == 16'h0 |=> code_q == 5'h00)
        else $error("code not zero");
    a_code_buf0: assert property (@(posedge aclk) disable iff (!aresetn)
        code_src[15] == 1'b0 && code_src[0] |=> code_q == 5'h11)
        else $error("buffer0 code wrong");
endmodule

// >>> verilog/can_accept_pkg.sv
package can_accept_pkg;
    localparam logic [7:0] global_mask_high_offset = 8'h00;
    localparam logic [7:0] global_mask_low_offset = 8'h04;
    localparam logic [7:0] last_buffer_mask_high_offset = 8'h08;
    localparam logic [7:0] last_buffer_mask_low_offset = 8'h0c;
    localparam logic [7:0] interrupt_enable_offset = 8'h10;
    localparam logic [7:0] interrupt_pending_offset = 8'h14;
    localparam logic [7:0] interrupt_clear_offset = 8'h18;
    localparam logic [7:0] interrupt_code_enable_offset = 8'h1c;
    localparam logic [7:0] node_status_and_code_offset = 8'h20;
    localparam logic [7:0] config_offset = 8'h24;
    localparam logic [15:0] reg_reset = 16'h0000;
    localparam int error_bit = 15;
    localparam int node_state_lsb = 5;
    localparam int code_flag_bit = 4;
    localparam int num_buffers = 15;
    localparam int last_buffer = 14;
    localparam logic [1:0] resp_okay = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;
endpackage
